// file: design/pabc_pkg.sv
// Package with register map, field layout and codes of the aux control
package pabc_pkg;
   localparam int          APB_AW            = 12;
   localparam logic [11:0] AUX_CTRL_OFFSET   = 12'h000;
   localparam logic [11:0] LEB_CTRL_OFFSET   = 12'h004;
   localparam logic [15:0] AUX_CTRL_RESET    = 16'h0000;
   localparam logic [15:0] AUX_CTRL_WMASK    = 16'h0f3f;
   localparam logic [15:0] LEB_CTRL_RESET    = 16'h0000;
   localparam logic [15:0] LEB_CTRL_WMASK    = 16'h0003;
   localparam int          LOW_CHOP_BIT      = 0;
   localparam int          HIGH_CHOP_BIT     = 1;
   localparam int          CHOP_SEL_LSB      = 2;
   localparam int          CHOP_SEL_MSB      = 5;
   localparam int          BLANK_SEL_LSB     = 8;
   localparam int          BLANK_SEL_MSB     = 11;
   localparam int          BLANK_FAULT_BIT   = 0;
   localparam int          BLANK_CLIM_BIT    = 1;
   localparam int          CHOP_DIV_DEFAULT  = 16;
   localparam int          CHOP_DIV_W        = 16;
   typedef enum logic [3:0] {
      PABC_SRC_NONE = 4'h0,
      PABC_SRC_CH1  = 4'h1,
      PABC_SRC_CH2  = 4'h2,
      PABC_SRC_CH3  = 4'h3
   } pabc_src_t;
endpackage

// file: design/pabc_chop_gen.sv
// Internal chop clock generator: square wave from a cycle divider
`timescale 1ns/10ps
module pabc_chop_gen #(
   parameter int HALF_PERIOD = pabc_pkg::CHOP_DIV_DEFAULT
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   output logic      chop_clk_o
);
   localparam int W = pabc_pkg::CHOP_DIV_W;
   localparam logic [W-1:0] LAST = W'(HALF_PERIOD - 1);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic         lvl_q;
   logic         lvl_d;

   // Count a half period, then toggle the level
   always_comb begin
      cnt_d = cnt_q + W'(1);
      lvl_d = lvl_q;
      if (cnt_q >= LAST) begin
         cnt_d = '0;
         lvl_d = ~lvl_q;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= '0;
         lvl_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         lvl_q <= lvl_d;
      end
   end

   assign chop_clk_o = lvl_q;
endmodule

// file: design/pabc_top.sv
// PWM auxiliary blanking and chop control with APB register slave
//
// Function
// - Blank source code 0 off, 1-3 channels
// - Active blank masks limit/fault per enables
// - Selected chop signal gates enabled outputs
// - High chop enable bit 1 gates high
// - Low chop enable bit 0 gates low
`timescale 1ns/10ps
module pabc_top #(
   parameter int CHOP_HALF_PERIOD = pabc_pkg::CHOP_DIV_DEFAULT
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        pwm_high_i,
   input  wire logic        pwm_low_i,
   input  wire logic        channel1_high_output_i,
   input  wire logic        channel2_high_output_i,
   input  wire logic        channel3_high_output_i,
   input  wire logic        current_limit_i,
   input  wire logic        fault_i,
   output logic             high_side_output_o,
   output logic             low_side_output_o,
   output logic             current_limit_o,
   output logic             fault_o,
   output logic             state_blank_o
);
   logic [15:0] aux_q;
   logic [15:0] aux_d;
   logic [15:0] leb_q;
   logic [15:0] leb_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        err_q;
   logic        err_d;
   logic        hi_q;
   logic        hi_d;
   logic        lo_q;
   logic        lo_d;
   logic        cl_q;
   logic        cl_d;
   logic        ft_q;
   logic        ft_d;
   logic        blank_q;
   logic        blank_d;
   logic        gen_chop;
   logic        chop_sig;
   logic        blank_sig;
   logic        setup;
   logic        access;
   logic        hit_aux;
   logic        hit_leb;

   // Pick one channel high-side signal; code 0 and reserved give 0
   function automatic logic pick_ch(input logic [3:0] code,
                                    input logic c1,
                                    input logic c2,
                                    input logic c3);
      logic r;
      r = 1'b0;
      case (code)
         pabc_pkg::PABC_SRC_CH1: r = c1;
         pabc_pkg::PABC_SRC_CH2: r = c2;
         pabc_pkg::PABC_SRC_CH3: r = c3;
         default:                r = 1'b0;
      endcase
      return r;
   endfunction

   // Merge byte-enabled write data into a 16-bit register
   function automatic logic [15:0] wmerge(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st,
                                          input logic [15:0] msk);
      logic [15:0] n;
      n = old;
      if (st[0]) n[7:0] = wd[7:0];
      if (st[1]) n[15:8] = wd[15:8];
      return n & msk;
   endfunction

   pabc_chop_gen #(
      .HALF_PERIOD (CHOP_HALF_PERIOD)
   ) u_chop_gen (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .chop_clk_o (gen_chop)
   );

   // APB decode; one access cycle, zero wait states
   assign setup    = psel_i & ~penable_i;
   assign access   = psel_i & penable_i;
   assign hit_aux  = (paddr_i == pabc_pkg::AUX_CTRL_OFFSET);
   assign hit_leb  = (paddr_i == pabc_pkg::LEB_CTRL_OFFSET);
   assign pready_o = 1'b1;

   // Register writes land at the access edge, reads captured at setup
   always_comb begin
      aux_d   = aux_q;
      leb_d   = leb_q;
      rdata_d = rdata_q;
      err_d   = err_q;
      if (access && pwrite_i && hit_aux) begin
         aux_d = wmerge(aux_q, pwdata_i, pstrb_i, pabc_pkg::AUX_CTRL_WMASK);
      end
      if (access && pwrite_i && hit_leb) begin
         leb_d = wmerge(leb_q, pwdata_i, pstrb_i, pabc_pkg::LEB_CTRL_WMASK);
      end
      if (setup) begin
         err_d   = ~(hit_aux | hit_leb);
         rdata_d = 32'h0000_0000;
         if (!pwrite_i && hit_aux) rdata_d = {16'h0000, aux_q};
         if (!pwrite_i && hit_leb) rdata_d = {16'h0000, leb_q};
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         aux_q   <= pabc_pkg::AUX_CTRL_RESET;
         leb_q   <= pabc_pkg::LEB_CTRL_RESET;
         rdata_q <= 32'h0000_0000;
         err_q   <= 1'b0;
      end else begin
         aux_q   <= aux_d;
         leb_q   <= leb_d;
         rdata_q <= rdata_d;
         err_q   <= err_d;
      end
   end

   assign prdata_o  = rdata_q;
   assign pslverr_o = access & err_q;

   // Source selection for blanking and chopping
   assign blank_sig = pick_ch(aux_q[pabc_pkg::BLANK_SEL_MSB:
                                    pabc_pkg::BLANK_SEL_LSB],
                              channel1_high_output_i,
                              channel2_high_output_i,
                              channel3_high_output_i);
   assign chop_sig = (aux_q[pabc_pkg::CHOP_SEL_MSB:pabc_pkg::CHOP_SEL_LSB]
                      == pabc_pkg::PABC_SRC_NONE) ? gen_chop :
                     pick_ch(aux_q[pabc_pkg::CHOP_SEL_MSB:
                                   pabc_pkg::CHOP_SEL_LSB],
                             channel1_high_output_i,
                             channel2_high_output_i,
                             channel3_high_output_i);

   // Output gating: chop the PWM pair, mask limit and fault inputs
   always_comb begin
      hi_d = pwm_high_i;
      lo_d = pwm_low_i;
      if (aux_q[pabc_pkg::HIGH_CHOP_BIT]) begin
         hi_d = pwm_high_i & chop_sig;
      end
      if (aux_q[pabc_pkg::LOW_CHOP_BIT]) begin
         lo_d = pwm_low_i & chop_sig;
      end
      blank_d = blank_sig;
      cl_d = current_limit_i &
             ~(blank_sig & leb_q[pabc_pkg::BLANK_CLIM_BIT]);
      ft_d = fault_i &
             ~(blank_sig & leb_q[pabc_pkg::BLANK_FAULT_BIT]);
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         hi_q    <= 1'b0;
         lo_q    <= 1'b0;
         cl_q    <= 1'b0;
         ft_q    <= 1'b0;
         blank_q <= 1'b0;
      end else begin
         hi_q    <= hi_d;
         lo_q    <= lo_d;
         cl_q    <= cl_d;
         ft_q    <= ft_d;
         blank_q <= blank_d;
      end
   end

   assign high_side_output_o = hi_q;
   assign low_side_output_o  = lo_q;
   assign current_limit_o    = cl_q;
   assign fault_o            = ft_q;
   assign state_blank_o      = blank_q;

   // Checks on the registered outputs and the chop select; the two gating checks skip the edge that left reset
   a_high_chop_and: assert property (@(posedge clk_i)
      disable iff (rst_i)
      !$past(rst_i) |-> high_side_output_o == $past(pwm_high_i &
         (~aux_q[pabc_pkg::HIGH_CHOP_BIT] | chop_sig)))
      else $error("high output gating wrong");
   a_low_chop_and: assert property (@(posedge clk_i)
      disable iff (rst_i)
      !$past(rst_i) |-> low_side_output_o == $past(pwm_low_i &
         (~aux_q[pabc_pkg::LOW_CHOP_BIT] | chop_sig)))
      else $error("low output gating wrong");
   a_chop_blocks_out: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (!rst_i && aux_q[1:0] == 2'h3 && !chop_sig) |=>
         !high_side_output_o && !low_side_output_o)
      else $error("output active while chop low");
   a_chop_gen_sel: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (!rst_i && aux_q[5:1] == 5'h01) |=>
         high_side_output_o == $past(pwm_high_i & gen_chop))
      else $error("generator not chop source");
   a_chop_ch2_sel: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (aux_q[5:2] == 4'h2) |-> chop_sig == channel2_high_output_i)
      else $error("channel 2 not chop source");
   a_blank_off: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (aux_q[11:8] == 4'h0 || aux_q[11:8] > 4'h3) |=> !state_blank_o)
      else $error("blank active when off");
   a_blank_ch3: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (!rst_i && aux_q[11:8] == 4'h3) |=>
         state_blank_o == $past(channel3_high_output_i))
      else $error("channel 3 blank wrong");
   a_blank_masks: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (blank_sig && leb_q[1]) |=> !current_limit_o)
      else $error("limit not blanked");
   a_fault_pass: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (!rst_i && (!blank_sig || !leb_q[0])) |=> fault_o == $past(fault_i))
      else $error("fault not passed");
   c_chop_high: cover property (@(posedge clk_i) disable iff (rst_i)
      aux_q[1] && pwm_high_i && !chop_sig);
   c_blank_fault: cover property (@(posedge clk_i) disable iff (rst_i)
      blank_sig && leb_q[0] && fault_i);
   c_apb_write: cover property (@(posedge clk_i) disable iff (rst_i)
      access && pwrite_i && hit_aux);
endmodule

// file: verif/pabc_stage_model.sv
// Half-bridge power stage model seen by the gated PWM pair
`timescale 1ns/10ps
module pabc_stage_model (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic high_on_i,
   input  wire logic low_on_i,
   output logic      node_o
);
   // Switch node follows the conducting switch, floats otherwise
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         node_o <= 1'b0;
      end else if (high_on_i && !low_on_i) begin
         node_o <= 1'b1;
      end else if (low_on_i && !high_on_i) begin
         node_o <= 1'b0;
      end else begin
         node_o <= ~node_o; // Floating or shoot-through: no stable level
      end
   end
endmodule

// file: verif/tb.sv
// Self-checking bench for the aux blanking and chop control
`timescale 1ns/10ps
module tb;
   logic        clk_i, rst_i, psel_i, penable_i, pwrite_i, e;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd, sv, xv;
   logic [3:0]  pstrb_i;
   logic        pready_o, pslverr_o, ph, pl, c1, c2, c3, cl, fl;
   logic        ho, lo, clo, flo, sbo, node;
   logic [15:0] aux, leb;
   int          fails, num_checks, n, m;

   pabc_top #(.CHOP_HALF_PERIOD(2)) pabc_top_inst (.clk_i(clk_i),
      .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .pwm_high_i(ph), .pwm_low_i(pl),
      .channel1_high_output_i(c1), .channel2_high_output_i(c2),
      .channel3_high_output_i(c3), .current_limit_i(cl), .fault_i(fl),
      .high_side_output_o(ho), .low_side_output_o(lo),
      .current_limit_o(clo), .fault_o(flo), .state_blank_o(sbo));
   pabc_stage_model pabc_stage_model_inst (.clk_i(clk_i), .rst_i(rst_i),
      .high_on_i(ho), .low_on_i(lo), .node_o(node));

   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Verdict and end of run
   task automatic stop_test;
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // One APB transfer, waiting for pready under a bound
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic err);
      int k;
      @(posedge clk_i);
      psel_i   <= 1'b1;
      pwrite_i <= w;
      paddr_i  <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (pready_o !== 1'b1 && k < 20);
      if (k >= 20) begin
         fails++;
         stop_test();
      end
      r = prdata_o;
      err = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask

   // Expected {high, low, limit, fault, blank} for a non-generator chop
   function automatic logic [4:0] model(input logic [15:0] a, l,
                      input logic h, w, x1, x2, x3, c, f);
      logic b, ch;
      b  = (a[11:8] == 4'h1) ? x1 : (a[11:8] == 4'h2) ? x2 :
           (a[11:8] == 4'h3) ? x3 : 1'b0;
      ch = (a[5:2] == 4'h1) ? x1 : (a[5:2] == 4'h2) ? x2 :
           (a[5:2] == 4'h3) ? x3 : 1'b0;
      model = {a[1] ? h & ch : h, a[0] ? w & ch : w,
               c & ~(b & l[1]), f & ~(b & l[0]), b};
   endfunction

   // Free-running bench clock
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // Main sequence
   initial begin
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
      {ph, pl, c1, c2, c3, cl, fl} = '0;
      pstrb_i = 4'h3;
      rst_i = 1'b1;
      fails = 0;
      num_checks = 0;
      void'($urandom(60));
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      apb(1'b0, 12'h000, 32'h0, rd, e);
      check(rd, 32'h00000000);
      apb(1'b1, 12'h000, 32'hffffffff, rd, e);
      apb(1'b0, 12'h000, 32'h0, rd, e);
      check(rd, 32'h00000f3f);
      apb(1'b0, 12'h008, 32'h0, rd, e);
      check({rd[30:0], e}, 32'h00000001);
      // Random configurations and inputs, every select code reachable except chop select 0 (generator)
      for (n = 0; n < 60; n++) begin
         aux = 16'($urandom) & 16'h0f3f;
         aux[5:2] = 4'($urandom_range(1, 15));
         leb = 16'($urandom) & 16'h0003;
         apb(1'b1, 12'h000, {16'h0, aux}, rd, e);
         apb(1'b1, 12'h004, {16'h0, leb}, rd, e);
         repeat (4) begin
            @(posedge clk_i);
            {ph, pl, c1, c2, c3, cl, fl} <= 7'($urandom);
            repeat (2) @(posedge clk_i);
            #1;
            sv = {27'h0, ho, lo, clo, flo, sbo};
            xv = {27'h0, model(aux, leb, ph, pl, c1, c2, c3, cl, fl)};
            check(sv, xv);
            // Power stage node follows the one switch that is on
            if (ho ^ lo) check({31'h0, node}, {31'h0, ho});
         end
      end
      // Internal generator chops high only, low passes
      apb(1'b1, 12'h000, 32'h00000002, rd, e);
      @(posedge clk_i);
      ph <= 1'b1;
      pl <= 1'b1;
      repeat (3) @(posedge clk_i);
      m = 0;
      n = 0;
      repeat (16) begin
         @(posedge clk_i);
         #1;
         n += int'(ho);
         m += int'(lo);
      end
      check(n, 8);
      check(m, 16);
      // Second reset in mid-run clears the register
      @(posedge clk_i);
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      apb(1'b0, 12'h000, 32'h0, rd, e);
      check(rd, 32'h00000000);
      stop_test();
   end
endmodule
